//--- design/tpc_cfg.svh
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// timing figures as printed, converted to 40 MHz cycles
`define TPC_CLK_MHZ 40
`define TPC_DIR_SETUP_NS 500
`define TPC_DIR_SETUP_CYC ((`TPC_DIR_SETUP_NS * `TPC_CLK_MHZ + 999) / 1000)
`define TPC_CMD_HOLD_NS 2000
`define TPC_CMD_HOLD_CYC ((`TPC_CMD_HOLD_NS * `TPC_CLK_MHZ + 999) / 1000)
`define TPC_READY_DROP_NS 1000
`define TPC_READY_DROP_CYC ((`TPC_READY_DROP_NS * `TPC_CLK_MHZ) / 1000)
`define TPC_ROW_CPS 120
`define TPC_ROW_CYC ((`TPC_CLK_MHZ * 1000000 + `TPC_ROW_CPS - 1) / `TPC_ROW_CPS)
`define TPC_FEED_CPS 170
`define TPC_FEED_CYC ((`TPC_CLK_MHZ * 1000000) / `TPC_FEED_CPS)
`define TPC_MAX_REVERSE 10
`define TPC_DELETE_ROW 8'hFF
`endif

//--- design/tpc_fifo.sv
`timescale 1ns/1ps
module tpc_fifo import tpc_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // tpc_fifo

//--- design/tpc_host.sv
`timescale 1ns/1ps
`include "tpc_cfg.svh"
// host end: queues rows (9 bits: dir + tracks) and paces them onto the port
module tpc_host import tpc_pkg::*; #(
  parameter int DEPTH = 32,
  parameter int SETUP_CYC = `TPC_DIR_SETUP_CYC,
  parameter int HOLD_CYC = `TPC_CMD_HOLD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  tpc_link_if.host link,
  input wire logic [7:0] row_data,
  input wire logic row_forward,
  input wire logic row_valid,
  output logic row_ready,
  input wire logic data_high,
  input wire logic out_high,
  output logic busy,
  output logic fault,
  output logic reverse_refused
);
  logic [8:0] q_data;
  logic q_valid;
  logic q_pop;
  logic [1:0] st_s1, st_s2;
  logic st_ok;
  tpc_host_state_t hstate;
  logic [15:0] cnt;
  logic [3:0] rev_count;
  logic out_true_ready, out_true_err;
  tpc_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_data({row_forward, row_data}),
    .in_valid(row_valid),
    .in_ready(row_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      st_s1 <= 2'h0;
      st_s2 <= 2'h0;
    end else if (ce) begin
      st_s1 <= {link.tape_error, link.punch_ready};
      st_s2 <= st_s1;
    end
  end
  assign out_true_ready = st_s2[0] ~^ link.out_pol;
  assign out_true_err = st_s2[1] ~^ link.out_pol;
  // ok line read directly as level; it only gates issue, never counted
  assign st_ok = out_true_ready && !out_true_err && !link.punch_system_ok_n;
  assign q_pop = (hstate == TPC_H_POP);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      hstate <= TPC_H_IDLE;
      cnt <= 16'h0;
      rev_count <= 4'h0;
      link.track <= 8'h00;
      link.punch_cmd <= 1'b0;
      link.forward <= 1'b1;
      link.data_pol <= 1'b1;
      link.out_pol <= 1'b1;
      busy <= 1'b0;
      fault <= 1'b0;
      reverse_refused <= 1'b0;
    end else if (ce) begin
      link.data_pol <= data_high;
      link.out_pol <= out_high;
      fault <= out_true_err;
      reverse_refused <= 1'b0;
      case (hstate)
        TPC_H_IDLE: begin
          busy <= 1'b0;
          // follow the new select, so a polarity change while idle never looks like a command
          link.punch_cmd <= ~data_high;
          if (q_valid && st_ok) begin
            if (!q_data[8] && rev_count == 4'(`TPC_MAX_REVERSE)) begin
              reverse_refused <= 1'b1;
              hstate <= TPC_H_POP;
            end else begin
              busy <= 1'b1;
              link.forward <= q_data[8];
              link.track <= link.data_pol ? q_data[7:0] : ~q_data[7:0];
              cnt <= 16'(SETUP_CYC);
              hstate <= TPC_H_SETUP;
            end
          end
        end
        TPC_H_SETUP: begin
          if (cnt == 16'h0) begin
            link.punch_cmd <= link.data_pol;
            cnt <= 16'(HOLD_CYC + 4);
            hstate <= TPC_H_PULSE;
            rev_count <= q_data[8] ? 4'h0 : rev_count + 1'b1;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        TPC_H_PULSE: begin
          if (cnt == 16'h0) begin
            link.punch_cmd <= ~link.data_pol;
            hstate <= TPC_H_WAIT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        TPC_H_WAIT: begin
          hstate <= TPC_H_POP;
        end
        TPC_H_POP: begin
          hstate <= TPC_H_IDLE;
        end
        default: hstate <= TPC_H_IDLE;
      endcase
    end
  end
endmodule // tpc_host

//--- design/tpc_link_if.sv
`timescale 1ns/1ps
interface tpc_link_if;
  logic [7:0] track;
  logic punch_cmd;
  logic forward;
  logic data_pol;
  logic out_pol;
  logic punch_ready;
  logic punch_system_ok_n;
  logic tape_error;
  logic low_supply;
  modport dev (input track, punch_cmd, forward, data_pol, out_pol,
    output punch_ready, punch_system_ok_n, tape_error, low_supply);
  modport host (output track, punch_cmd, forward, data_pol, out_pol,
    input punch_ready, punch_system_ok_n, tape_error, low_supply);
endinterface

//--- design/tpc_pkg.sv
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_IDLE = 2'b00,
    TPC_MOVE = 2'b01,
    TPC_FEED = 2'b11
  } tpc_state_t;
  typedef enum logic [2:0] {
    TPC_H_IDLE = 3'b000,
    TPC_H_SETUP = 3'b001,
    TPC_H_PULSE = 3'b011,
    TPC_H_WAIT = 3'b010,
    TPC_H_POP = 3'b110
  } tpc_host_state_t;
endpackage

//--- design/tpc_punch.sv
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_punch import tpc_pkg::*; #(
  parameter int ROW_CYC = `TPC_ROW_CYC,
  parameter int FEED_CYC = `TPC_FEED_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  tpc_link_if.dev link,
  input wire logic feed_sw,
  input wire logic delete_sw,
  input wire logic supply_low,
  input wire logic mech_fault,
  output logic [7:0] row_holes,
  output logic sprocket,
  output logic advance,
  output logic backspace
);
  ////////////////////////////////////////////////////////////////
  logic [7:0] track_s1, track_s2;
  logic [1:0] cmd_s1, cmd_s2, fwd_s1, fwd_s2;
  logic [1:0] sw_s1, sw_s2;
  logic [1:0] misc_s1, misc_s2;
  logic [1:0] flt_s1, flt_s2;
  logic cmd_prev;
  logic [31:0] timer;
  tpc_state_t state;
  logic cmd_true;
  logic ready_int;
  // inputs are pins: two flops each before use
  always_ff @(posedge clock) begin
    if (rst) begin
      track_s1 <= 8'h00;
      track_s2 <= 8'h00;
      // idle command under the reset polarity, so no false edge after reset
      cmd_s1 <= 2'h2;
      cmd_s2 <= 2'h2;
      fwd_s1 <= 2'h3;
      fwd_s2 <= 2'h3;
      sw_s1 <= 2'h0;
      sw_s2 <= 2'h0;
      misc_s1 <= 2'h0;
      misc_s2 <= 2'h0;
      flt_s1 <= 2'h0;
      flt_s2 <= 2'h0;
    end else if (ce) begin
      track_s1 <= link.track;
      track_s2 <= track_s1;
      cmd_s1 <= {link.data_pol, link.punch_cmd};
      cmd_s2 <= cmd_s1;
      fwd_s1 <= {link.out_pol, link.forward};
      fwd_s2 <= fwd_s1;
      sw_s1 <= {delete_sw, feed_sw};
      sw_s2 <= sw_s1;
      misc_s1 <= {1'b0, supply_low};
      misc_s2 <= misc_s1;
      flt_s1 <= {1'b0, mech_fault};
      flt_s2 <= flt_s1;
    end
  end
  // data polarity: high select means true-high convention
  assign cmd_true = cmd_s2[0] ~^ cmd_s2[1];
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_prev <= 1'b0;
    end else if (ce) begin
      cmd_prev <= cmd_true;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= TPC_IDLE;
      timer <= 32'h0;
      row_holes <= 8'h00;
      sprocket <= 1'b0;
      advance <= 1'b0;
      backspace <= 1'b0;
    end else if (ce) begin
      advance <= 1'b0;
      backspace <= 1'b0;
      case (state)
        TPC_IDLE: begin
          if (sw_s2 != 2'h0) begin
            state <= TPC_FEED;
            timer <= 32'(FEED_CYC - 1);
            advance <= 1'b1;
            sprocket <= 1'b1;
            row_holes <= sw_s2[1] ? `TPC_DELETE_ROW : 8'h00;
          end else if (cmd_true && !cmd_prev) begin
            state <= TPC_MOVE;
            timer <= 32'(ROW_CYC - 1);
            if (fwd_s2[0]) begin
              advance <= 1'b1;
              sprocket <= 1'b1;
              row_holes <= cmd_s2[1] ? track_s2 : ~track_s2;
            end else begin
              backspace <= 1'b1;
              sprocket <= 1'b0;
              row_holes <= 8'h00;
            end
          end
        end
        TPC_MOVE: begin
          if (timer == 32'h0) begin
            state <= TPC_IDLE;
            sprocket <= 1'b0;
            row_holes <= 8'h00;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        TPC_FEED: begin
          if (timer != 32'h0) begin
            timer <= timer - 1'b1;
          end else if (sw_s2 != 2'h0) begin
            timer <= 32'(FEED_CYC - 1);
            advance <= 1'b1;
            row_holes <= sw_s2[1] ? `TPC_DELETE_ROW : 8'h00;
          end else begin
            state <= TPC_IDLE;
            sprocket <= 1'b0;
            row_holes <= 8'h00;
          end
        end
        default: state <= TPC_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // ready falls the cycle after the edge is seen, well under 1 us
  assign ready_int = (state == TPC_IDLE) && !(cmd_true && !cmd_prev) && sw_s2 == 2'h0;
  always_ff @(posedge clock) begin
    if (rst) begin
      link.punch_ready <= 1'b0;
      link.punch_system_ok_n <= 1'b1;
      link.tape_error <= 1'b0;
      link.low_supply <= 1'b0;
    end else if (ce) begin
      link.punch_ready <= ready_int ~^ fwd_s2[1];
      link.punch_system_ok_n <= flt_s2[0];
      link.tape_error <= flt_s2[0] ~^ fwd_s2[1];
      link.low_supply <= misc_s2[0];
    end
  end
endmodule // tpc_punch

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int RC = 50;
  logic clock, rst, feed_sw, delete_sw, supply_low, mech_fault, row_forward, row_valid;
  logic row_ready, data_high, out_high, busy, fault, reverse_refused, sprocket, advance;
  logic backspace, sp, saw_full;
  logic [7:0] row_data, row_holes, hv;
  int num_errors = 0, check_count = 0, n_adv = 0, n_back = 0, n_ref = 0;
  tpc_link_if link();
  tpc_host tpc_host_inst (.clock(clock), .rst(rst), .ce(1'b1), .link(link), .row_data(row_data),
    .row_forward(row_forward), .row_valid(row_valid), .row_ready(row_ready),
    .data_high(data_high), .out_high(out_high), .busy(busy), .fault(fault),
    .reverse_refused(reverse_refused));
  tpc_punch #(.ROW_CYC(RC), .FEED_CYC(RC)) tpc_punch_inst (.clock(clock), .rst(rst), .ce(1'b1),
    .link(link), .feed_sw(feed_sw), .delete_sw(delete_sw), .supply_low(supply_low),
    .mech_fault(mech_fault), .row_holes(row_holes), .sprocket(sprocket), .advance(advance),
    .backspace(backspace));
  tpc_link_chk #(.ROW_CYC(RC)) tpc_link_chk_inst (.clock(clock), .rst(rst), .track(link.track),
    .punch_cmd(link.punch_cmd), .forward(link.forward), .data_pol(link.data_pol),
    .out_pol(link.out_pol), .punch_ready(link.punch_ready),
    .punch_system_ok_n(link.punch_system_ok_n), .tape_error(link.tape_error),
    .low_supply(link.low_supply));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // sample on the falling edge, where registered outputs have settled
  always @(negedge clock) begin
    if (advance === 1'b1) n_adv++;
    if (backspace === 1'b1) n_back++;
    if (reverse_refused === 1'b1) n_ref++;
    if (advance === 1'b1 || backspace === 1'b1) {hv, sp} = {row_holes, sprocket};
    if (row_valid && row_ready === 1'b0) saw_full = 1'b1;
  end
  ////////////////////////////////////////
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // valid held high across the burst, so the fifo sees a true back-to-back stream
  task automatic push(logic fwd, logic [7:0] d, int n);
    row_data <= d;
    row_forward <= fwd;
    row_valid <= 1'b1;
    repeat (n) begin
      @(negedge clock);
      while (row_ready !== 1'b1) @(negedge clock);
      @(posedge clock);
    end
    row_valid <= 1'b0;
  endtask
  task automatic wait_for(int a, int b, int c, int lim);
    for (int i = 0; i < lim && (n_adv < a || n_back < b || n_ref < c); i++) @(posedge clock);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("ERROR watchdog expected 0 seen 1");
    summarize();
  end
  initial begin
    int k;
    {rst, feed_sw, delete_sw, supply_low, mech_fault, row_forward, row_valid} = 7'h40;
    {row_data, data_high, out_high, saw_full} = 11'h006;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    supply_low <= 1'b1;
    push(1'b1, 8'hA5, 34);
    wait_for(34, 0, 0, 8000);
    chk("forward rows", 32'h22, n_adv);
    chk("fifo full", 32'h1, saw_full);
    chk("forward holes", 32'h14B, {hv, sp});
    $display("test forward burst done");
    push(1'b0, 8'hFF, 11);
    wait_for(34, 10, 1, 4000);
    chk("reverse rows", 32'hA, n_back);
    chk("reverse refused", 32'h1, n_ref);
    chk("reverse holes", 32'h0, {hv, sp});
    chk("advance on reverse", 32'h22, n_adv);
    $display("test reverse done");
    mech_fault <= 1'b1;
    for (k = 0; k < 100 && fault !== 1'b1; k++) @(posedge clock);
    push(1'b1, 8'h3C, 1);
    wait_for(35, 0, 0, 400);
    chk("punch on fault", 32'h22, n_adv);
    mech_fault <= 1'b0;
    wait_for(35, 0, 0, 800);
    chk("row after fault", 32'h79, {hv, sp});
    $display("test fault done");
    k = n_adv;
    feed_sw <= 1'b1;
    wait_for(k + 3, 0, 0, 800);
    feed_sw <= 1'b0;
    delete_sw <= 1'b1;
    chk("feed rows", k + 3, n_adv);
    chk("feed holes", 32'h1, {hv, sp});
    wait_for(k + 6, 0, 0, 800);
    delete_sw <= 1'b0;
    chk("delete holes", 32'h1FF, {hv, sp});
    $display("test feed delete done");
    rst <= 1'b1;
    data_high <= 1'b0;
    out_high <= 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    k = n_adv;
    push(1'b1, 8'h5A, 1);
    wait_for(k + 1, 0, 0, 800);
    chk("inverted polarity", 32'hB5, {hv, sp});
    $display("test polarity done");
    summarize();
  end
endmodule // tb

//--- tb/tpc_link_chk.sv
`timescale 1ns/1ps
module tpc_link_chk #(
  parameter int ROW_CYC = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] track,
  input wire logic punch_cmd,
  input wire logic forward,
  input wire logic data_pol,
  input wire logic out_pol,
  input wire logic punch_ready,
  input wire logic punch_system_ok_n,
  input wire logic tape_error,
  input wire logic low_supply
);
  localparam int SETUP = 20;
  localparam int HOLD = 80;
  localparam int RET = ROW_CYC + 20;
  logic cmd_true, ready_true, fwd_q, armed;
  int dir_cnt, cmd_cnt, low_cnt;
  assign cmd_true = punch_cmd ~^ data_pol;
  assign ready_true = punch_ready ~^ out_pol;
  always_ff @(posedge clock) fwd_q <= forward;
  always_ff @(posedge clock) dir_cnt <= (rst || forward != fwd_q) ? 0 : dir_cnt + 1;
  always_ff @(posedge clock) cmd_cnt <= (rst || !cmd_true) ? 0 : cmd_cnt + 1;
  always_ff @(posedge clock) low_cnt <= (rst || ready_true) ? 0 : low_cnt + 1;
  // only commanded rows are timed; fault or manual drops of ready are not
  always_ff @(posedge clock) armed <= rst ? 1'b0 : (cmd_true | (armed & !ready_true));
  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_cmd_start; $rose(cmd_true); endsequence
  sequence s_row_start; $rose(cmd_true) ##[1:40] !ready_true; endsequence
  property p_dir_setup; s_cmd_start |-> dir_cnt + 1 >= SETUP; endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("direction setup short");
  property p_dir_hold; cmd_true |-> $stable(forward); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved in command");
  property p_data_hold; cmd_true && cmd_cnt < HOLD |-> $stable(track); endproperty
  a_data_hold: assert property (p_data_hold) else $error("tracks moved too early");
  property p_cmd_width; $fell(cmd_true) |-> cmd_cnt >= HOLD; endproperty
  a_cmd_width: assert property (p_cmd_width) else $error("command too short");
  property p_ready_drop; s_cmd_start |-> ##[1:40] !ready_true; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready did not drop");
  property p_ready_gate;
    s_cmd_start |-> $past(ready_true) && !$past(punch_system_ok_n) && $past(tape_error) != out_pol;
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("command while not ready");
  property p_ready_back; s_row_start |-> ##[1:RET] ready_true; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready did not return");
  property p_row_rate; $rose(ready_true) && armed |-> low_cnt >= ROW_CYC - 5; endproperty
  a_row_rate: assert property (p_row_rate) else $error("row faster than allowed");
endmodule // tpc_link_chk
